//--- i2ca_pkg.sv
/*
  Constants, state type and timing counts for the I2C converter front end.
  Assumes a single 125 MHz reference clock; the I2C pins are asynchronous to it.
*/
// Functional notes
// - After an acknowledged write, exactly one configuration byte is accepted.
// - The written byte only chooses the conversion rate; nothing else changes.
// - The conversion rate is 60 Hz until a byte selects otherwise.
// - Eighth byte bit is half_rate_select: one gives 30 Hz, zero gives 60 Hz.
// - After an acknowledged read, 16 result bits go out, changing on SCL falls.
// - Result leaves most significant bit first, result_top_bit down to result_bottom_bit.
// - The end of a read starts a new conversion without further command.
// - Address presented during a conversion is answered with NACK.
// - Write then repeated START then read is supported after a finished conversion.
// - Combined write/read starts next conversion after 16 bits or STOP, new rate.
// - Acknowledged write ended by STOP discards the result and starts a conversion.
// - The global call address with a write request is acknowledged too.
// - STOP ending a global call write applies any byte and starts a conversion.
// - Global call write stopped without data starts a conversion, rate unchanged.
// - The fixed seven-bit slave address is 0010100.
// - Configuration bits are sampled on rising SCL edges.
// - Direction bit after the address is one for read, zero for write.
// - After reset the rate is 60 Hz, one conversion runs, then the result holds.
package i2ca_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned FAST_RATE_HZ = 60;
  localparam int unsigned SLOW_RATE_HZ = 30;
  localparam int unsigned FAST_CONV_CYC = CLK_HZ / FAST_RATE_HZ;
  localparam int unsigned SLOW_CONV_CYC = CLK_HZ / SLOW_RATE_HZ;
  localparam int CNT_W = 22;
  localparam logic [6:0] OWN_ADDR = 7'h14;
  localparam logic [6:0] GLOBAL_ADDR = 7'h77;
  localparam logic RW_READ = 1'b1;
  localparam int HALF_RATE_BIT = 0;
  localparam logic RATE_FAST = 1'b0;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [4:0] SLOT_BYTE = 5'h08;
  localparam logic [4:0] SLOT_LAST = 5'h11;
  localparam logic [2:0] SYNC_RESET = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_WDATA,
    ST_WACK,
    ST_RDATA,
    ST_IGNORE
  } i2ca_state_t;
endpackage : i2ca_pkg

//--- i2ca_conv_if.sv
/*
  Link between the I2C front end and the conversion sequencer.
  Assumes both ends run on ref_clk; start is a one-cycle pulse.
*/
`timescale 1ns/1ps
interface i2ca_conv_if;
  logic start;
  logic half_rate;
  logic busy;
  logic [15:0] result;
  modport ctrl (output start, output half_rate, input busy, input result);
  modport conv (input start, input half_rate, output busy, output result);
endinterface : i2ca_conv_if

//--- i2ca_conv.sv
/*
  Conversion sequencer: times one conversion and captures the modulator word.
  Assumes sample_data is on ref_clk and valid in the cycle the count ends.
*/
`timescale 1ns/1ps
module i2ca_conv
  import i2ca_pkg::*;
#(
  parameter int unsigned FAST_CYC = FAST_CONV_CYC,
  parameter int unsigned SLOW_CYC = SLOW_CONV_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:0] sample_data,
  i2ca_conv_if.conv cv
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] term;
  logic slow;
  logic done;

  assign term = slow ? CNT_W'(SLOW_CYC - 1) : CNT_W'(FAST_CYC - 1);
  assign done = cv.busy && (cnt == term);

  // Reset leaves the sequencer busy so that one conversion runs before any access.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cv.busy <= 1'b1;
    end else if (done) begin
      cv.busy <= 1'b0;
    end else if (cv.start) begin
      cv.busy <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (!cv.busy) begin
      cnt <= '0;
    end else if (cnt != term) begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slow <= RATE_FAST;
    end else if (cv.start && !cv.busy) begin
      slow <= cv.half_rate;
    end
  end

  // The result only changes at the end of a conversion, so a read never sees a torn word.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cv.result <= RESULT_RESET;
    end else if (done) begin
      cv.result <= sample_data;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  conv_length_a: assert property ($fell(cv.busy) |-> $past(cnt) == $past(term))
    else $error("conversion ended at the wrong count");
  slow_length_a: assert property ($fell(cv.busy) && $past(slow) |-> $past(cnt) == CNT_W'(SLOW_CYC - 1))
    else $error("slow conversion has the wrong length");
  start_busy_a: assert property (cv.start && !cv.busy |=> cv.busy [*2])
    else $error("start did not begin a conversion");
endmodule : i2ca_conv

//--- i2ca_top.sv
/*
  I2C slave front end and conversion control of a 16-bit converter.
  Assumes an external pull-up on SDA; scl and sda_in are asynchronous pins.
*/
`timescale 1ns/1ps
module i2ca_top
  import i2ca_pkg::*;
#(
  parameter int unsigned FAST_CYC = FAST_CONV_CYC,
  parameter int unsigned SLOW_CYC = SLOW_CONV_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic [15:0] sample_data,
  output logic sda_out,
  output logic sda_oe,
  output logic conv_busy,
  output logic half_rate_select
);
  i2ca_conv_if cv ();

  i2ca_conv #(
    .FAST_CYC(FAST_CYC),
    .SLOW_CYC(SLOW_CYC)
  ) u_conv (
    .ref_clk(ref_clk),
    .rst(rst),
    .sample_data(sample_data),
    .cv(cv)
  );

  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic sda_bit;
  i2ca_state_t st;
  logic [4:0] slot;
  logic [7:0] shreg;
  logic [15:0] rdsh;
  logic is_read;
  logic addr_hit;
  logic ack_addr;
  logic wr_byte;
  logic read_done;
  logic conv_go;
  logic armed;
  logic cfg_valid;
  logic cfg_bit;
  logic rate;
  logic start_q;

  // Bit 0 feeds only bit 1; edges are found between bits 1 and 2.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_q <= SYNC_RESET;
      sda_q <= SYNC_RESET;
    end else begin
      scl_q <= {scl_q[1:0], scl};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign start_cond = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign stop_cond = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  assign sda_bit = sda_q[1];

  assign addr_hit = (shreg[7:1] == OWN_ADDR) || ((shreg[7:1] == GLOBAL_ADDR) && (shreg[0] != RW_READ));
  assign ack_addr = scl_fall && (st == ST_ADDR) && (slot == SLOT_BYTE) && addr_hit && !cv.busy;
  assign wr_byte = scl_fall && (st == ST_WDATA) && (slot == SLOT_BYTE);
  assign read_done = scl_rise && (st == ST_RDATA) && (slot == SLOT_LAST);
  assign conv_go = (stop_cond && armed) || read_done;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= ST_IDLE;
      slot <= '0;
      shreg <= '0;
      rdsh <= RESULT_RESET;
      is_read <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      st <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (start_cond) begin
      // A repeated START keeps any pending byte and arming for the read that follows.
      st <= ST_ADDR;
      slot <= '0;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      case (st)
        ST_ADDR, ST_WDATA: begin
          shreg <= {shreg[6:0], sda_bit};
          slot <= slot + 1'b1;
        end
        ST_RDATA: begin
          if (slot == SLOT_LAST || (slot == SLOT_BYTE && sda_bit)) begin
            st <= ST_IGNORE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st)
        ST_ADDR: begin
          if (slot == SLOT_BYTE) begin
            if (ack_addr) begin
              st <= ST_AACK;
              sda_oe <= 1'b1;
              is_read <= (shreg[0] == RW_READ);
            end else begin
              st <= ST_IGNORE;
            end
          end
        end
        ST_AACK: begin
          slot <= '0;
          if (is_read) begin
            st <= ST_RDATA;
            rdsh <= cv.result;
            sda_oe <= ~cv.result[15];
          end else begin
            st <= ST_WDATA;
            sda_oe <= 1'b0;
          end
        end
        ST_WDATA: begin
          if (slot == SLOT_BYTE) begin
            st <= ST_WACK;
            sda_oe <= 1'b1;
          end
        end
        ST_WACK: begin
          // Any further byte is left unanswered, so the master sees a NACK.
          st <= ST_IGNORE;
          sda_oe <= 1'b0;
        end
        ST_RDATA: begin
          slot <= slot + 1'b1;
          if (slot + 1'b1 == SLOT_BYTE || slot + 1'b1 == SLOT_LAST) begin
            sda_oe <= 1'b0;
          end else begin
            rdsh <= {rdsh[14:0], 1'b0};
            sda_oe <= ~rdsh[14];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      armed <= 1'b0;
      cfg_valid <= 1'b0;
      cfg_bit <= RATE_FAST;
    end else if (conv_go) begin
      armed <= 1'b0;
      cfg_valid <= 1'b0;
    end else begin
      if (ack_addr) begin
        armed <= 1'b1;
      end
      if (wr_byte) begin
        cfg_valid <= 1'b1;
        cfg_bit <= shreg[HALF_RATE_BIT];
      end
    end
  end

  // The rate is only committed when a conversion launches, so an unfinished write is harmless.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rate <= RATE_FAST;
    end else if (conv_go && cfg_valid) begin
      rate <= cfg_bit;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      start_q <= 1'b0;
    end else begin
      start_q <= conv_go;
    end
  end

  assign cv.start = start_q;
  assign cv.half_rate = rate;
  assign sda_out = 1'b0;
  assign conv_busy = cv.busy;
  assign half_rate_select = rate;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence conv_launch_s;
    cv.start ##1 cv.busy;
  endsequence

  busy_nack_a: assert property ((st == ST_AACK) && ($past(st) == ST_ADDR) |-> $past(!cv.busy))
    else $error("address acknowledged during a conversion");
  addr_match_a: assert property ((st == ST_AACK) && ($past(st) == ST_ADDR)
      |-> ($past(shreg[7:1]) == OWN_ADDR) || ($past(shreg) == {GLOBAL_ADDR, 1'b0}))
    else $error("acknowledged a foreign address");
  rate_hold_a: assert property ($changed(rate) |-> $past(conv_go) && $past(cfg_valid))
    else $error("rate changed without a launched configuration");
  rate_pick_a: assert property (conv_go && cfg_valid |=> (rate == $past(cfg_bit)) ##0 conv_launch_s)
    else $error("new rate not applied at launch");
  read_conv_a: assert property (read_done |=> conv_launch_s)
    else $error("read end did not start a conversion");
  stop_conv_a: assert property (stop_cond && armed |=> conv_launch_s)
    else $error("stop after acknowledged access did not start a conversion");
  msb_first_a: assert property ((st == ST_RDATA) && ($past(st) == ST_AACK) |-> sda_oe == !cv.result[15])
    else $error("first read bit is not the top bit");
  fall_change_a: assert property ((st == ST_RDATA) && ($past(st) == ST_RDATA) && $changed(sda_oe) |-> $past(scl_fall))
    else $error("read data changed away from a falling SCL");
  one_byte_a: assert property ((st == ST_IGNORE) && ($past(st) == ST_WACK) |-> !sda_oe [*2])
    else $error("second write byte acknowledged");
endmodule : i2ca_top

//--- i2ca_master_model.sv
/*
  Behavioural I2C bus master that stands on the far side of the converter front end.
  Assumes a pull-up on SDA and a slave pulling low while sda_oe is high.
*/
`timescale 1ns/1ps
module i2ca_master_model (
  input wire logic ref_clk,
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic scl,
  output logic sda
);
  logic sda_drv;

  // Open drain: a released line reads high through the pull-up, a driven one shows the slave's level.
  assign sda = sda_drv & (sda_oe ? sda_out : 1'b1);

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // A quarter of the SCL period; four of them make a 128 ns bit.
  task q;
    repeat (4) @(negedge ref_clk);
  endtask : q

  task start;
    sda_drv = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_drv = 1'b0;
    q;
    scl = 1'b0;
    q;
  endtask : start

  task stop;
    sda_drv = 1'b0;
    q;
    scl = 1'b1;
    q;
    sda_drv = 1'b1;
    q;
  endtask : stop

  task bit_io(input logic b, output logic r);
    sda_drv = b;
    q;
    scl = 1'b1;
    q;
    r = sda;
    q;
    scl = 1'b0;
    q;
  endtask : bit_io

  // Eight bits most significant first, then the acknowledge slot.
  task byte_io(input logic [7:0] wb, input logic ab, output logic [7:0] rb, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(wb[i], rb[i]);
    end
    bit_io(ab, ack);
  endtask : byte_io
endmodule : i2ca_master_model

//--- testbench.sv
/*
  Self-checking bench for the I2C converter front end.
  Assumes shortened conversion counts and the bus master model beside it.
*/
`timescale 1ns/1ps
module testbench;
  import i2ca_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic sda;
  logic [15:0] sample_data = 16'hA53C;
  logic sda_out;
  logic sda_oe;
  logic conv_busy;
  logic half_rate_select;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int busy_run = 0;
  int busy_last = 0;

  always #4 ref_clk = ~ref_clk;

  // Busy cycles are counted at the falling edge, where the flag has settled; a finished run is kept.
  always @(negedge ref_clk) begin
    if (conv_busy === 1'b1) begin
      busy_run <= busy_run + 1;
    end else if (busy_run != 0) begin
      busy_last <= busy_run;
      busy_run <= 0;
    end
  end

  i2ca_top #(.FAST_CYC(200), .SLOW_CYC(400)) u_dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .scl(scl),
    .sda_in(sda),
    .sample_data(sample_data),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .conv_busy(conv_busy),
    .half_rate_select(half_rate_select)
  );

  i2ca_master_model u_mst (
    .ref_clk(ref_clk),
    .sda_oe(sda_oe),
    .sda_out(sda_out),
    .scl(scl),
    .sda(sda)
  );

  task test_done;
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // The whole sequence needs about 5500 cycles; the margin covers a slow design.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      test_done;
    end
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task addr(input logic [6:0] a, input logic rw, output logic ack);
    logic [7:0] rb;
    u_mst.start;
    u_mst.byte_io({a, rw}, 1'b1, rb, ack);
  endtask : addr

  task wbyte(input logic [7:0] b, output logic ack);
    logic [7:0] rb;
    u_mst.byte_io(b, 1'b1, rb, ack);
  endtask : wbyte

  task rd(input logic [15:0] exp);
    logic ack;
    logic [15:0] v;
    addr(OWN_ADDR, 1'b1, ack);
    chk(16'(ack), 16'h0000);
    u_mst.byte_io(8'hFF, 1'b0, v[15:8], ack);
    u_mst.byte_io(8'hFF, 1'b1, v[7:0], ack);
    chk(v, exp);
  endtask : rd

  // Holds the master until the conversion is over before it starts a transaction.
  task wait_idle;
    int n;
    n = 0;
    while (conv_busy !== 1'b0 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    chk(16'(n < 2000), 16'h0001);
  endtask : wait_idle

  // Waits for the running conversion to end, then compares its whole length in cycles.
  task busy_len(input int exp);
    int n;
    n = 0;
    while (conv_busy === 1'b1 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    chk(16'(n < 1000), 16'h0001);
    chk(16'(busy_last), 16'(exp));
  endtask : busy_len

  task t_busy_read;
    logic ack;
    chk(16'(half_rate_select), 16'h0000);
    addr(OWN_ADDR, 1'b1, ack);
    chk(16'(ack), 16'h0001);
    u_mst.stop;
    wait_idle;
    rd(16'hA53C);
    repeat (4) @(negedge ref_clk);
    chk(16'(conv_busy), 16'h0001);
    u_mst.stop;
  endtask : t_busy_read

  task t_write_slow;
    logic ack;
    wait_idle;
    sample_data = 16'h5AC3;
    addr(OWN_ADDR, 1'b0, ack);
    chk(16'(ack), 16'h0000);
    wbyte(8'h01, ack);
    chk(16'(ack), 16'h0000);
    wbyte(8'h00, ack);
    chk(16'(ack), 16'h0001);
    u_mst.stop;
    repeat (3) @(negedge ref_clk);
    chk(16'(half_rate_select), 16'h0001);
    busy_len(400);
  endtask : t_write_slow

  task t_write_read;
    logic ack;
    wait_idle;
    addr(OWN_ADDR, 1'b0, ack);
    chk(16'(ack), 16'h0000);
    wbyte(8'hFE, ack);
    chk(16'(ack), 16'h0000);
    rd(16'h5AC3);
    repeat (4) @(negedge ref_clk);
    chk(16'(conv_busy), 16'h0001);
    chk(16'(half_rate_select), 16'h0000);
    u_mst.stop;
  endtask : t_write_read

  task t_discard;
    logic ack;
    wait_idle;
    sample_data = 16'h1234;
    addr(OWN_ADDR, 1'b0, ack);
    chk(16'(ack), 16'h0000);
    u_mst.stop;
    busy_len(200);
    rd(16'h1234);
    u_mst.stop;
  endtask : t_discard

  task t_global;
    logic ack;
    wait_idle;
    addr(GLOBAL_ADDR, 1'b1, ack);
    chk(16'(ack), 16'h0001);
    u_mst.stop;
    addr(7'h15, 1'b0, ack);
    chk(16'(ack), 16'h0001);
    u_mst.stop;
    addr(GLOBAL_ADDR, 1'b0, ack);
    chk(16'(ack), 16'h0000);
    u_mst.stop;
    busy_len(200);
    chk(16'(half_rate_select), 16'h0000);
    wait_idle;
    addr(GLOBAL_ADDR, 1'b0, ack);
    wbyte(8'h01, ack);
    chk(16'(ack), 16'h0000);
    u_mst.stop;
    repeat (3) @(negedge ref_clk);
    chk(16'(half_rate_select), 16'h0001);
    chk(16'(conv_busy), 16'h0001);
    wait_idle;
  endtask : t_global

  // A read cut short by a NACK after the first byte starts no conversion until the STOP.
  task t_short_read;
    logic ack;
    logic [7:0] b;
    wait_idle;
    addr(OWN_ADDR, 1'b1, ack);
    chk(16'(ack), 16'h0000);
    u_mst.byte_io(8'hFF, 1'b1, b, ack);
    chk(16'(b), 16'h0012);
    chk(16'(conv_busy), 16'h0000);
    u_mst.stop;
    chk(16'(conv_busy), 16'h0001);
  endtask : t_short_read

  initial begin
    repeat (3) @(negedge ref_clk);
    chk(16'(conv_busy), 16'h0001);
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    t_busy_read;
    t_write_slow;
    t_write_read;
    t_discard;
    t_global;
    t_short_read;
    test_done;
  end
endmodule : testbench
